// ### rtl/freq_prot_pkg.sv
/*
 * Shared constants and carrier types for the over/underfrequency stages.
 * Assumes frequencies in 0.01 Hz units and voltage in 0.01 %Un units,
 * delivered by the tracking subsystem, frequency sampled once per time base tick.
 */
package freq_prot_pkg;
    localparam int N_STG        = 4;
    localparam int N_ALL        = 8;
    localparam int N_REF        = 3;
    localparam int N_GRP        = 8;
    localparam int FW           = 14;
    localparam int TW           = 19;
    localparam int CW           = 16;
    localparam int RW           = 16;
    localparam int CLK_MHZ      = 100;
    localparam int BASE_MS      = 5;
    localparam int TICK_CYC     = BASE_MS * 1000 * CLK_MHZ;
    localparam int PRE_MS       = 20;
    localparam int PRE_TICKS    = PRE_MS / BASE_MS;
    localparam logic [FW-1:0] HYST_CHZ  = 14'h0002;
    localparam logic [FW-1:0] OVER_DEF  = 14'h13EC;
    localparam logic [FW-1:0] UNDER_DEF = 14'h1324;
    localparam logic [FW-1:0] UV_OFF    = 14'h0000;
    localparam int RATIO_FRAC   = 10;

    typedef enum logic [2:0] {
        MODE_ON      = 3'b000,
        MODE_BLOCKED = 3'b001,
        MODE_TEST    = 3'b010,
        MODE_TESTBLK = 3'b011,
        MODE_OFF     = 3'b100
    } node_mode_t;

    typedef enum logic [1:0] {
        ST_NORMAL  = 2'b00,
        ST_START   = 2'b01,
        ST_TRIP    = 2'b10,
        ST_BLOCKED = 2'b11
    } stage_status_t;

    typedef enum logic [1:0] {
        STORE_ON   = 2'b01,
        STORE_OFF  = 2'b10,
        STORE_BOTH = 2'b11
    } event_store_t;

    typedef struct packed {
        logic [FW-1:0] pickup;
        logic [TW-1:0] delay_ticks;
        logic          used;
    } stage_cfg_t;

    typedef struct packed {
        logic [2:0]    stage;
        logic [1:0]    kind;
        logic          on;
        logic [31:0]   stamp;
        logic [FW-1:0] pre_freq;
        logic [FW-1:0] fault_freq;
        logic [2:0]    group;
    } event_rec_t;
endpackage : freq_prot_pkg

// ### rtl/frequency_protection_block.sv
/*
 * Four over- and four underfrequency stages with definite delay,
 * node mode, status forcing, undervoltage block, events and counters.
 * Assumes settings are static between writes and a free running stamp.
 * Stage index 0..3 over, 4..7 under.
 */
`timescale 1ns/100ps
module frequency_protection_block
    import freq_prot_pkg::*;
#(
    parameter int TICK = freq_prot_pkg::TICK_CYC
) (
    input  wire logic                         mclk_i,
    input  wire logic                         rstn_i,
    input  wire logic [freq_prot_pkg::FW-1:0] freq_ref_i [freq_prot_pkg::N_REF],
    input  wire logic [1:0]                   ref_sel_i,
    input  wire logic [freq_prot_pkg::FW-1:0] volt_i,
    input  wire logic [freq_prot_pkg::FW-1:0] uv_block_i,
    input  wire logic                         func_active_i,
    input  wire logic [freq_prot_pkg::N_ALL-1:0] stage_en_i,
    input  wire freq_prot_pkg::stage_cfg_t    grp_cfg_i
                 [freq_prot_pkg::N_GRP][freq_prot_pkg::N_ALL],
    input  wire logic [2:0]                   group_i,
    input  wire logic                         ln_mode_allow_i,
    input  wire freq_prot_pkg::node_mode_t    logical_node_mode_i,
    input  wire logic                         force_allow_i,
    input  wire freq_prot_pkg::stage_status_t stage_status_override_i
                 [freq_prot_pkg::N_ALL],
    input  wire logic [freq_prot_pkg::N_ALL-1:0] block_i,
    input  wire freq_prot_pkg::event_store_t  store_sel_i,
    input  wire logic                         cnt_clr_i,
    input  wire logic [31:0]                  stamp_i,
    output logic [freq_prot_pkg::N_ALL-1:0]   start_o,
    output logic [freq_prot_pkg::N_ALL-1:0]   trip_o,
    output logic [freq_prot_pkg::N_ALL-1:0]   blocked_o,
    output logic [freq_prot_pkg::RW-1:0]      ratio_o [freq_prot_pkg::N_ALL],
    output freq_prot_pkg::node_mode_t         mode_o,
    output logic                              evt_valid_o,
    output freq_prot_pkg::event_rec_t         evt_o,
    output logic [freq_prot_pkg::CW-1:0]      start_cnt_o,
    output logic [freq_prot_pkg::CW-1:0]      trip_cnt_o,
    output logic [freq_prot_pkg::CW-1:0]      blocked_cnt_o
);
    import freq_prot_pkg::*;

    logic [31:0]   tick_cnt_reg;
    logic          tick;
    logic [FW-1:0] freq_reg;
    logic [FW-1:0] hist_reg [PRE_TICKS];
    node_mode_t    mode;
    logic          mode_block;
    logic [N_ALL-1:0] pick_reg;
    logic [N_ALL-1:0] st_reg, tr_reg, bl_reg;
    logic [N_ALL-1:0] st_prev_reg, tr_prev_reg, bl_prev_reg;
    logic [TW-1:0] tmr_reg [N_ALL];

    // 5 ms time base
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_cnt_reg <= '0;
        end else if (tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
        end
    end
    assign tick = (tick_cnt_reg == 32'(TICK - 1));

    // reference sampling and pre-trigger history
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            freq_reg <= '0;
            for (int i = 0; i < PRE_TICKS; i++) begin
                hist_reg[i] <= '0;
            end
        end else if (tick) begin
            freq_reg <= (ref_sel_i < 2'(N_REF)) ? freq_ref_i[ref_sel_i]
                                                : freq_ref_i[0];
            hist_reg[0] <= freq_reg;
            for (int i = 1; i < PRE_TICKS; i++) begin
                hist_reg[i] <= hist_reg[i-1];
            end
        end
    end

    assign mode = ln_mode_allow_i ? logical_node_mode_i : MODE_ON;
    assign mode_o = mode;
    assign mode_block = (mode == MODE_BLOCKED) || (mode == MODE_TESTBLK)
                     || (mode == MODE_OFF);

    genvar g;
    generate
        for (g = 0; g < N_ALL; g++) begin : g_stage
            localparam bit UNDER = (g >= N_STG);
            stage_cfg_t    cfg;
            logic          live, over_lvl, rel_lvl, pick_next, blk;
            logic [FW-1:0] ps;
            logic [FW+RATIO_FRAC-1:0] num;
            assign cfg  = grp_cfg_i[group_i][g];
            assign live = func_active_i && stage_en_i[g] && cfg.used
                       && (mode != MODE_OFF);
            assign ps   = (cfg.pickup == '0) ? (UNDER ? UNDER_DEF : OVER_DEF)
                                             : cfg.pickup;
            assign over_lvl = UNDER ? (freq_reg < ps) : (freq_reg > ps);
            assign rel_lvl  = UNDER ? (freq_reg < ps + HYST_CHZ)
                                    : (freq_reg + HYST_CHZ > ps);
            assign pick_next = pick_reg[g] ? rel_lvl : over_lvl;
            assign blk = block_i[g] || mode_block
                      || (UNDER && uv_block_i != UV_OFF
                          && volt_i < uv_block_i);
            assign num = {freq_reg, {RATIO_FRAC{1'b0}}};

            always_ff @(posedge mclk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    pick_reg[g] <= 1'b0;
                    ratio_o[g]  <= '0;
                end else if (tick) begin
                    pick_reg[g] <= live && pick_next;
                    ratio_o[g]  <= RW'(num / ps);
                end
            end

            always_ff @(posedge mclk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    st_reg[g]  <= 1'b0;
                    tr_reg[g]  <= 1'b0;
                    bl_reg[g]  <= 1'b0;
                    tmr_reg[g] <= '0;
                end else if (!live) begin
                    st_reg[g]  <= 1'b0;
                    tr_reg[g]  <= 1'b0;
                    bl_reg[g]  <= 1'b0;
                    tmr_reg[g] <= '0;
                end else if (force_allow_i
                             && stage_status_override_i[g] != ST_NORMAL) begin
                    st_reg[g] <= stage_status_override_i[g] == ST_START
                              || stage_status_override_i[g] == ST_TRIP;
                    tr_reg[g] <= stage_status_override_i[g] == ST_TRIP;
                    bl_reg[g] <= stage_status_override_i[g] == ST_BLOCKED;
                end else if (tick) begin
                    st_reg[g] <= pick_reg[g] && !blk;
                    bl_reg[g] <= pick_reg[g] && blk;
                    if (pick_reg[g] && !blk) begin
                        if (tmr_reg[g] >= cfg.delay_ticks) begin
                            tr_reg[g] <= 1'b1;
                        end else begin
                            tmr_reg[g] <= tmr_reg[g] + TW'(1);
                        end
                    end else begin
                        tr_reg[g]  <= 1'b0;
                        tmr_reg[g] <= '0;
                    end
                end
            end
        end
    endgenerate

    assign start_o   = st_reg;
    assign trip_o    = tr_reg;
    assign blocked_o = bl_reg;

    // event selection: lowest stage, start then trip then blocked
    logic [N_ALL-1:0] st_chg, tr_chg, bl_chg;
    logic             any_chg, store_ok, found;
    logic [2:0]       e_stg;
    logic [1:0]       e_kind;
    logic             e_on;
    assign st_chg = st_reg ^ st_prev_reg;
    assign tr_chg = tr_reg ^ tr_prev_reg;
    assign bl_chg = bl_reg ^ bl_prev_reg;

    always_comb begin
        found  = 1'b0;
        e_stg  = '0;
        e_kind = ST_NORMAL;
        e_on   = 1'b0;
        for (int i = 0; i < N_ALL; i++) begin
            if (!found && st_chg[i]) begin
                found  = 1'b1;
                e_stg  = 3'(i);
                e_kind = ST_START;
                e_on   = st_reg[i];
            end
            if (!found && tr_chg[i]) begin
                found  = 1'b1;
                e_stg  = 3'(i);
                e_kind = ST_TRIP;
                e_on   = tr_reg[i];
            end
            if (!found && bl_chg[i]) begin
                found  = 1'b1;
                e_stg  = 3'(i);
                e_kind = ST_BLOCKED;
                e_on   = bl_reg[i];
            end
        end
    end
    assign any_chg  = found;
    assign store_ok = e_on ? store_sel_i[0] : store_sel_i[1];

    // one change reported per cycle; remaining ones follow
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_prev_reg <= '0;
            tr_prev_reg <= '0;
            bl_prev_reg <= '0;
        end else if (any_chg) begin
            unique case (e_kind)
                ST_START:   st_prev_reg[e_stg] <= st_reg[e_stg];
                ST_TRIP:    tr_prev_reg[e_stg] <= tr_reg[e_stg];
                ST_BLOCKED: bl_prev_reg[e_stg] <= bl_reg[e_stg];
                default:    st_prev_reg[e_stg] <= st_reg[e_stg];
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            evt_valid_o <= 1'b0;
            evt_o       <= '0;
        end else begin
            evt_valid_o <= any_chg && store_ok;
            if (any_chg && store_ok) begin
                evt_o.stage      <= e_stg;
                evt_o.kind       <= e_kind;
                evt_o.on         <= e_on;
                evt_o.stamp      <= stamp_i;
                evt_o.pre_freq   <= hist_reg[PRE_TICKS-1];
                evt_o.fault_freq <= freq_reg;
                evt_o.group      <= group_i;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            start_cnt_o   <= '0;
            trip_cnt_o    <= '0;
            blocked_cnt_o <= '0;
        end else if (cnt_clr_i) begin
            start_cnt_o   <= '0;
            trip_cnt_o    <= '0;
            blocked_cnt_o <= '0;
        end else if (any_chg && e_on) begin
            if (e_kind == ST_START) begin
                start_cnt_o <= start_cnt_o + CW'(1);
            end
            if (e_kind == ST_TRIP) begin
                trip_cnt_o <= trip_cnt_o + CW'(1);
            end
            if (e_kind == ST_BLOCKED) begin
                blocked_cnt_o <= blocked_cnt_o + CW'(1);
            end
        end
    end
endmodule : frequency_protection_block

// ### bench/freq_prot_props.sv
/* checker for the frequency stages: gating, counters, mode, events.
   bound into frequency_protection_block; one clock domain. */
`timescale 1ns/100ps
module freq_prot_props
    import freq_prot_pkg::*;
(
    input wire logic             mclk_i,
    input wire logic             rstn_i,
    input wire logic             func_active_i,
    input wire logic [N_ALL-1:0] stage_en_i,
    input wire logic             force_allow_i,
    input wire logic             ln_mode_allow_i,
    input wire node_mode_t       logical_node_mode_i,
    input wire event_store_t     store_sel_i,
    input wire logic             cnt_clr_i,
    input wire logic [N_ALL-1:0] start_o,
    input wire logic [N_ALL-1:0] trip_o,
    input wire logic [N_ALL-1:0] blocked_o,
    input wire node_mode_t       mode_o,
    input wire logic             evt_valid_o,
    input wire logic [CW-1:0]    start_cnt_o,
    input wire logic [CW-1:0]    trip_cnt_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    wire logic [N_ALL-1:0] act = start_o | trip_o | blocked_o;
    sequence no_force2;
        !force_allow_i ##1 !force_allow_i;
    endsequence
    sequence moved;
        store_sel_i == STORE_BOTH && act != $past(act);
    endsequence
    a_inactive_quiet: assert property (
        !func_active_i ##0 no_force2 |-> act == '0)
        else $error("stage output while function inactive");
    a_disabled_quiet: assert property (
        no_force2 |-> (act & ~$past(stage_en_i)) == '0)
        else $error("disabled stage drives an output");
    a_off_quiet: assert property (
        mode_o == MODE_OFF ##0 no_force2 |-> act == '0)
        else $error("stage output in mode off");
    a_trip_has_start: assert property (
        (trip_o & ~start_o) == '0)
        else $error("trip without start");
    a_start_unblocked: assert property (
        (start_o & blocked_o) == '0)
        else $error("start and blocked together");
    a_cnt_clear: assert property (
        cnt_clr_i |=> start_cnt_o == '0 && trip_cnt_o == '0)
        else $error("counters not cleared");
    a_cnt_no_drop: assert property (
        start_cnt_o < $past(start_cnt_o) |-> $past(cnt_clr_i))
        else $error("counter dropped without clear");
    a_mode_select: assert property (
        ln_mode_allow_i |-> mode_o == logical_node_mode_i)
        else $error("effective mode differs from setting");
    a_mode_default: assert property (
        !ln_mode_allow_i |-> mode_o == MODE_ON)
        else $error("mode not on while setting disallowed");
    a_change_logged: assert property (
        moved |-> ##[1:30] evt_valid_o)
        else $error("status change without event");
endmodule : freq_prot_props
bind frequency_protection_block freq_prot_props i_props (.*);

// ### bench/freq_source.sv
/* model of the frequency tracking side: refreshes the three references
   and the voltage once per time base tick. assumes one clock. */
`timescale 1ns/100ps
module freq_source
    import freq_prot_pkg::*;
#(
    parameter int TICK = 10
) (
    input  wire logic          mclk_i,
    input  wire logic          rstn_i,
    input  wire logic [FW-1:0] f_want_i [N_REF],
    input  wire logic [FW-1:0] v_want_i,
    output logic      [FW-1:0] freq_ref_o [N_REF],
    output logic      [FW-1:0] volt_o
);
    int cnt;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt        <= 0;
            volt_o     <= 14'h2710;
            freq_ref_o <= '{default: 14'h1388};
        end else begin
            cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
            if (cnt == TICK - 1) begin
                freq_ref_o <= f_want_i;
                volt_o     <= v_want_i;
            end
        end
    end
endmodule : freq_source

// ### bench/testbench.sv
/* self-checking bench for frequency_protection_block with a short tick.
   assumes freq_source as the tracking side and the bound checker. */
`timescale 1ns/100ps
module testbench;
    import freq_prot_pkg::*;
    localparam int TK = 10;
    logic          mclk_i = 0;
    logic          rstn_i = 0;
    logic [FW-1:0] f_want [N_REF];
    logic [FW-1:0] fref [N_REF];
    logic [FW-1:0] v_want, volt, uv;
    logic [1:0]    rsel;
    logic          fact, lnal, fal, clr, ev;
    logic [7:0]    en, blk, st, tr, bl;
    stage_cfg_t    cfg [N_GRP][N_ALL];
    logic [2:0]    grp;
    node_mode_t    lnm, mode;
    stage_status_t ovr [N_ALL];
    logic [31:0]   stamp = '0;
    event_store_t  ssel;
    logic [RW-1:0] ratio [N_ALL];
    event_rec_t    evt, sev, lev;
    logic [CW-1:0] scnt, tcnt, bcnt;
    int            fails = 0, num_checks = 0, cyc = 0, nev = 0;
    freq_source #(.TICK(TK)) i_src (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .f_want_i(f_want), .v_want_i(v_want), .freq_ref_o(fref),
        .volt_o(volt));
    frequency_protection_block #(.TICK(TK)) i_dut (.mclk_i(mclk_i),
        .rstn_i(rstn_i), .freq_ref_i(fref), .ref_sel_i(rsel),
        .volt_i(volt), .uv_block_i(uv), .func_active_i(fact),
        .stage_en_i(en), .grp_cfg_i(cfg), .group_i(grp),
        .ln_mode_allow_i(lnal), .logical_node_mode_i(lnm),
        .force_allow_i(fal), .stage_status_override_i(ovr),
        .block_i(blk), .store_sel_i(ssel), .cnt_clr_i(clr),
        .stamp_i(stamp), .start_o(st), .trip_o(tr), .blocked_o(bl),
        .ratio_o(ratio), .mode_o(mode), .evt_valid_o(ev), .evt_o(evt),
        .start_cnt_o(scnt), .trip_cnt_o(tcnt), .blocked_cnt_o(bcnt));
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        stamp <= stamp + 1;
        if (ev === 1'b1 && evt.on === 1'b1 && evt.kind === 2'd1)
            sev <= evt;
        if (ev === 1'b1) begin
            lev <= evt;
            nev <= nev + 1;
        end
        cyc++;
        if (cyc == 6000) begin
            fails++;
            stop_test();
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task ticks(input int n);
        repeat (n * TK) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : ticks
    task t_over;
        @(posedge mclk_i);
        en <= 8'h01;
        rsel <= 2'd1;
        f_want[1] <= 14'h13EE; // 51.02 Hz on second reference only
        ticks(5);
        chk(st ^ tr, 8'h01);
        ticks(5);
        chk(st, 8'h01);
        chk(tr, 8'h01);
        chk(ratio[0], 16'h0400);
        chk(scnt, 16'h0001);
        chk({sev.stage, sev.group}, 6'h00);
        chk(sev.fault_freq, 14'h13EE);
        @(posedge mclk_i);
        f_want[1] <= 14'h13EB; // inside the release band
        ticks(6);
        chk(st, 8'h01);
        @(posedge mclk_i);
        f_want[1] <= 14'h13E9;
        clr <= 1'b1;
        @(posedge mclk_i);
        clr <= 1'b0;
        ticks(6);
        chk(st | tr, 8'h00);
        chk(scnt, 16'h0000);
    endtask : t_over
    task t_under;
        @(posedge mclk_i);
        en <= 8'hF0;
        rsel <= 2'd0;
        f_want[0] <= 14'h1321;
        uv <= 14'h03E8;
        v_want <= 14'h01F4;
        ticks(10);
        chk(st, 8'h00);
        chk(bl, 8'hF0);
        @(posedge mclk_i);
        v_want <= 14'h2328;
        ticks(10);
        chk(st & tr, 8'hF0);
        @(posedge mclk_i);
        v_want <= 14'h01F4;
        uv <= 14'h0000;
        f_want[0] <= 14'h1388;
        ticks(6);
        @(posedge mclk_i);
        blk <= 8'h20;
        f_want[0] <= 14'h1321;
        ticks(10);
        chk(bl, 8'h20);
        chk(st, 8'hD0);
        @(posedge mclk_i);
        blk <= 8'h00;
        f_want[0] <= 14'h1388;
        ticks(6);
    endtask : t_under
    task t_gate;
        @(posedge mclk_i);
        f_want[0] <= 14'h1321;
        ticks(10);
        @(posedge mclk_i);
        grp <= 3'd1;
        ticks(2);
        chk(st | tr | bl, 8'h00);
        @(posedge mclk_i);
        grp <= 3'd0;
        fact <= 1'b0;
        ticks(2);
        chk(st | tr | bl, 8'h00);
        @(posedge mclk_i);
        fact <= 1'b1;
        en <= 8'h00;
        ticks(2);
        chk(st | tr | bl, 8'h00);
        @(posedge mclk_i);
        en <= 8'hF0;
        lnal <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk_i);
            lnm <= node_mode_t'(i);
            ticks(8);
            chk(16'(mode), 16'(i));
            chk(st, (i == 0 || i == 2) ? 8'hF0 : 8'h00);
        end
    endtask : t_gate
    task t_force;
        @(posedge mclk_i);
        lnm <= MODE_ON;
        f_want[0] <= 14'h1388;
        en <= 8'hF1;
        fal <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk_i);
            ovr[0] <= stage_status_t'(k);
            ticks(1);
            chk({bl[0], tr[0], st[0]}, 3'(12'h8C8 >> (3 * k)));
        end
    endtask : t_force
    task t_store;
        int n0;
        ticks(6);
        @(posedge mclk_i);
        f_want[0] <= 14'h1390;
        ticks(2);
        @(posedge mclk_i);
        clr <= 1'b1;
        ssel <= STORE_OFF;
        @(posedge mclk_i);
        clr <= 1'b0;
        ovr[0] <= ST_TRIP;
        n0 = nev;
        ticks(1);
        chk(16'(nev - n0), 16'h0001);
        chk({lev.kind, lev.on}, 3'h6);
        chk(scnt, 16'h0001);
        chk(tcnt, 16'h0001);
        chk(lev.pre_freq, 14'h1388);
        chk(lev.fault_freq, 14'h1390);
        @(posedge mclk_i);
        ssel <= STORE_ON;
        ovr[0] <= ST_BLOCKED;
        n0 = nev;
        ticks(1);
        chk(16'(nev - n0), 16'h0001);
        chk({lev.stage, lev.kind, lev.on}, 6'h07);
        chk(bcnt, 16'h0001);
    endtask : t_store
    task stop_test;
        $display("checks %0d failures %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    initial begin
        f_want = '{default: 14'h1388};
        v_want = 14'h2710;
        uv = 14'h0000;
        rsel = 2'd0;
        {fact, lnal, fal, clr} = 4'b1000;
        {en, blk, grp} = '0;
        ssel = STORE_BOTH;
        lnm = MODE_ON;
        ovr = '{default: ST_NORMAL};
        for (int g = 0; g < N_GRP; g++) begin
            for (int s = 0; s < N_ALL; s++) begin
                cfg[g][s] = '{'0, 19'h0_0002, g == 0};
            end
        end
        repeat (6) @(posedge mclk_i);
        rstn_i <= 1'b1;
        t_over();
        t_under();
        t_gate();
        t_force();
        t_store();
        stop_test();
    end
endmodule : testbench
